/* hdl/asi_pkg.sv */
package asi_pkg;

    // ------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------
    localparam int         CMD_BITS   = 8;
    localparam int         CMD_RW_BIT = 6;       // 1 = read, 0 = write
    localparam int         CMD_RS_LSB = 0;       // Two-bit register select
    localparam logic [1:0] RS_STATUS  = 2'h0;    // Command on write, status on read
    localparam logic [1:0] RS_CONFIG  = 2'h1;
    localparam logic [1:0] RS_FILTER  = 2'h2;
    localparam logic [1:0] RS_DATA    = 2'h3;

    // ------------------------------------------------------------
    // Register widths, fields and reset values
    // ------------------------------------------------------------
    localparam int          DATA_W         = 16;
    localparam int          CONFIG_W       = 24;
    localparam int          FILTER_W       = 8;
    localparam int          STATUS_W       = 8;
    localparam int          SHIFT_W        = 24;  // Widest register, MSB aligned
    localparam int          STATUS_RDY_BIT = 7;
    localparam logic [23:0] CONFIG_RST     = 24'h000000;
    localparam logic [7:0]  FILTER_RST     = 8'h00;
    localparam logic [15:0] DATA_RST       = 16'h0000;

    // ------------------------------------------------------------
    // Counts and timing
    // ------------------------------------------------------------
    localparam int RESET_ONES     = 32;     // Ones on the data input that reset the port
    localparam int RECOVER_READS  = 24;     // Read clocks ahead of the ones on a shared line
    localparam int CLK_PERIOD_NS  = 50;
    localparam int RDY_LEAD_NS    = 200;    // Ready high this long before a result update
    localparam int RDY_LEAD_CYC   = (RDY_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_MAX_KHZ   = 3000;
    localparam int SCLK_HALF_CYC  = (1000000 + 2 * SCLK_MAX_KHZ * CLK_PERIOD_NS - 1)
                                    / (2 * SCLK_MAX_KHZ * CLK_PERIOD_NS);

    // Bits that follow the command byte for each register
    function automatic logic [4:0] reg_len(input logic [1:0] rs);
        logic [4:0] len;
        len = 5'd8;
        unique case (rs)
            RS_STATUS: len = 5'd8;
            RS_CONFIG: len = 5'd24;
            RS_FILTER: len = 5'd8;
            RS_DATA:   len = 5'd16;
        endcase
        return len;
    endfunction : reg_len

endpackage : asi_pkg

/* hdl/asi_link_if.sv */
`timescale 1ns/1ps
interface asi_link_if;

    logic sclk;       // Serial clock, idles high, made by the host
    logic cs_n;       // Chip select, active low
    logic din;        // Host to device data
    logic dout;       // Device to host data
    logic dout_oe_n;  // Device drives dout while low
    logic rdy_n;      // Result ready, active low
    logic miso;       // Line level seen by the host, pulled up when released

    // Pull-up on the released data-out line
    assign miso = dout_oe_n ? 1'b1 : dout;

    modport dev (input sclk, input cs_n, input din, output dout, output dout_oe_n,
                 output rdy_n);
    modport host (output sclk, output cs_n, output din, input miso, input rdy_n);

endinterface : asi_link_if

/* hdl/asi_dev_end.sv */
`timescale 1ns/1ps
// Overview of operation
// (RQ1) Data 16 bits, configuration 24, command/filter 8
// (RQ2) Long registers move as consecutive 8-bit chunks
// (RQ3) Arm register access right after eighth command clock
// (RQ4) Host writes command byte, then eight filter bits
// (RQ5) Output released during write operations
// (RQ6) Input data ignored during read operations
// (RQ7) Written bits arrive most significant first
// (RQ8) Read bits leave most significant first
// (RQ9) Host runs clock idle high, second-edge sampling
// (RQ10) Host serial clock at most 3 MHz
// (RQ11) Ready shown by status bit and low pin
// (RQ12) Works with chip select tied low
// (RQ13) Every access starts with a command write
// (RQ14) 32 ones reset port and registers
// (RQ15) Ready low on result, high after read/update
// (RQ16) Shared line recovery: 24 reads, 32 ones
// (RQ17) Sample on rising edge, drive after falling
module asi_dev_end #(
    parameter int RESET_ONES   = asi_pkg::RESET_ONES,
    parameter int RDY_LEAD_CYC = asi_pkg::RDY_LEAD_CYC
) (
    // System clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Serial link, device side
    asi_link_if.dev          link,
    // Conversion results in
    input  wire logic [15:0] result_data,
    input  wire logic        result_valid,
    // Register contents and port reset pulse out
    output logic      [23:0] config_q,
    output logic      [7:0]  filter_q,
    output logic             iface_reset
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (RESET_ONES < 9 || RESET_ONES > 63) begin : g_bad_ones
        $error("RESET_ONES out of range");
    end
    if (RDY_LEAD_CYC < 1 || RDY_LEAD_CYC > 255) begin : g_bad_lead
        $error("RDY_LEAD_CYC out of range");
    end

    typedef enum {ST_CMD, ST_WRITE, ST_READ} asi_dev_st_t;
    localparam logic [5:0] ONES_LAST = 6'(RESET_ONES - 1);
    localparam logic [7:0] LEAD_INIT = 8'(RDY_LEAD_CYC);

    asi_dev_st_t  state_r;
    logic [4:0]   bit_cnt_r;
    logic [5:0]   ones_r;
    logic [1:0]   rs_r, cmd_rs;
    logic [7:0]   filter_r, lead_r;
    logic [15:0]  data_r, hold_r;
    logic [2:0]   cfg_sync_r, rd_sync_r, srst_sync_r;
    logic [23:0]  rx_sr_r, tx_sr_r, config_r, rx_nxt, read_word;
    logic         cfg_tog_r, rd_tog_r, srst_tog_r, dout_r, dout_oe_n_r, rdy_s1_r, rdy_s2_r;
    logic         rdy_n_r, frame, ones_hit, last_bit, cmd_read, cfg_evt, rd_evt, srst_evt;

    // ------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------
    // Frame decode and shared helpers
    assign frame     = !link.cs_n;                                         // RQ12
    assign ones_hit  = link.din && (ones_r == ONES_LAST);
    assign rx_nxt    = {rx_sr_r[22:0], link.din};                          // RQ7
    assign last_bit  = (bit_cnt_r == asi_pkg::reg_len(rs_r) - 5'd1);
    assign cmd_rs    = rx_nxt[asi_pkg::CMD_RS_LSB +: 2];
    assign cmd_read  = rx_nxt[asi_pkg::CMD_RW_BIT];
    // Register contents, MSB aligned for shifting out
    always_comb begin
        read_word = 24'h000000;
        unique case (cmd_rs)
            asi_pkg::RS_STATUS: read_word[23 - (7 - asi_pkg::STATUS_RDY_BIT)] = !rdy_s2_r; // RQ11
            asi_pkg::RS_CONFIG: read_word = config_r;
            asi_pkg::RS_FILTER: read_word = {filter_r, 16'h0000};
            asi_pkg::RS_DATA:   read_word = {data_r, 8'h00};
        endcase
    end
    // Ready level into the link domain for the status bit
    always_ff @(posedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            rdy_s1_r <= 1'b1;
            rdy_s2_r <= 1'b1;
        end else begin
            rdy_s1_r <= rdy_n_r;
            rdy_s2_r <= rdy_s1_r;
        end
    end
    // Run of ones on the data input, watched in every state
    always_ff @(posedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            ones_r <= 6'h00;
        end else if (frame) begin
            if (!link.din || ones_hit) begin
                ones_r <= 6'h00;
            end else begin
                ones_r <= ones_r + 6'h01;                                  // RQ14
            end
        end
    end
    // Access sequencer, sampled on the rising edge
    always_ff @(posedge link.sclk or negedge reset_n) begin               // RQ17
        if (!reset_n) begin
            state_r   <= ST_CMD;
            bit_cnt_r <= 5'h00;
            rs_r      <= asi_pkg::RS_STATUS;
        end else if (frame) begin
            if (ones_hit) begin
                state_r   <= ST_CMD;                                       // RQ14
                bit_cnt_r <= 5'h00;
            end else begin
                unique case (state_r)
                    ST_CMD: begin
                        if (bit_cnt_r == 5'd7) begin
                            bit_cnt_r <= 5'h00;
                            rs_r      <= cmd_rs;
                            if (cmd_read) begin
                                state_r <= ST_READ;                        // RQ3
                            end else if (cmd_rs != asi_pkg::RS_STATUS) begin
                                state_r <= ST_WRITE;                       // RQ3
                            end
                        end else begin
                            bit_cnt_r <= bit_cnt_r + 5'h01;
                        end
                    end
                    ST_WRITE, ST_READ: begin
                        if (last_bit) begin
                            state_r   <= ST_CMD;                           // RQ13
                            bit_cnt_r <= 5'h00;
                        end else begin
                            bit_cnt_r <= bit_cnt_r + 5'h01;                // RQ2
                        end
                    end
                endcase
            end
        end
    end
    // Input shifter, frozen while a read runs
    always_ff @(posedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sr_r <= 24'h000000;
        end else if (frame && state_r != ST_READ) begin                    // RQ6
            rx_sr_r <= rx_nxt;
        end
    end
    // Output shifter, loaded as the command byte ends
    always_ff @(posedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_sr_r <= 24'h000000;
        end else if (frame) begin
            if (state_r == ST_CMD && bit_cnt_r == 5'd7 && cmd_read) begin
                tx_sr_r <= read_word;
            end else if (state_r == ST_READ) begin
                tx_sr_r <= {tx_sr_r[22:0], 1'b0};                          // RQ8
            end
        end
    end
    // Writable registers and their change events
    always_ff @(posedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            config_r   <= asi_pkg::CONFIG_RST;
            filter_r   <= asi_pkg::FILTER_RST;
            cfg_tog_r  <= 1'b0;
            srst_tog_r <= 1'b0;
        end else if (frame) begin
            if (ones_hit) begin
                config_r   <= asi_pkg::CONFIG_RST;                         // RQ14
                filter_r   <= asi_pkg::FILTER_RST;
                cfg_tog_r  <= !cfg_tog_r;
                srst_tog_r <= !srst_tog_r;
            end else if (state_r == ST_WRITE && last_bit) begin
                if (rs_r == asi_pkg::RS_CONFIG) begin
                    config_r  <= rx_nxt;                                   // RQ1
                    cfg_tog_r <= !cfg_tog_r;
                end else if (rs_r == asi_pkg::RS_FILTER) begin
                    filter_r  <= rx_nxt[7:0];                              // RQ4
                    cfg_tog_r <= !cfg_tog_r;
                end
            end
        end
    end
    // Completed data register read
    always_ff @(posedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_tog_r <= 1'b0;
        end else if (frame && !ones_hit && state_r == ST_READ && last_bit
                     && rs_r == asi_pkg::RS_DATA) begin
            rd_tog_r <= !rd_tog_r;                                         // RQ15
        end
    end
    // Data out after the falling edge; released at once when select rises
    always_ff @(negedge link.sclk or negedge reset_n or posedge link.cs_n) begin
        if (!reset_n) begin
            dout_r      <= 1'b1;
            dout_oe_n_r <= 1'b1;
        end else if (link.cs_n) begin
            dout_r      <= 1'b1;
            dout_oe_n_r <= 1'b1;
        end else begin
            dout_r      <= tx_sr_r[23];                                    // RQ17
            dout_oe_n_r <= (state_r != ST_READ);                           // RQ5
        end
    end
    assign link.dout      = dout_r;
    assign link.dout_oe_n = dout_oe_n_r;
    assign link.rdy_n     = rdy_n_r;

    // ------------------------------------------------------------
    // System clock domain
    // ------------------------------------------------------------
    // Toggle synchronisers for link events
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cfg_sync_r  <= 3'h0;
            rd_sync_r   <= 3'h0;
            srst_sync_r <= 3'h0;
        end else begin
            cfg_sync_r  <= {cfg_sync_r[1:0], cfg_tog_r};
            rd_sync_r   <= {rd_sync_r[1:0], rd_tog_r};
            srst_sync_r <= {srst_sync_r[1:0], srst_tog_r};
        end
    end
    assign cfg_evt  = cfg_sync_r[2] ^ cfg_sync_r[1];
    assign rd_evt   = rd_sync_r[2] ^ rd_sync_r[1];
    assign srst_evt = srst_sync_r[2] ^ srst_sync_r[1];
    // Register copies; the link side holds them steady across the event
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            config_q    <= asi_pkg::CONFIG_RST;
            filter_q    <= asi_pkg::FILTER_RST;
            iface_reset <= 1'b0;
        end else begin
            iface_reset <= srst_evt;
            if (cfg_evt) begin
                config_q <= config_r;
                filter_q <= filter_r;
            end
        end
    end
    // Result register and ready pin; an update beats a read in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_r  <= asi_pkg::DATA_RST;
            hold_r  <= asi_pkg::DATA_RST;
            lead_r  <= 8'h00;
            rdy_n_r <= 1'b1;
        end else if (srst_evt) begin
            data_r  <= asi_pkg::DATA_RST;                                  // RQ14
            lead_r  <= 8'h00;
            rdy_n_r <= 1'b1;
        end else if (result_valid) begin
            hold_r  <= result_data;
            lead_r  <= LEAD_INIT;
            rdy_n_r <= 1'b1;                                               // RQ15
        end else if (lead_r == 8'h01) begin
            data_r  <= hold_r;
            lead_r  <= 8'h00;
            rdy_n_r <= 1'b0;                                               // RQ11
        end else begin
            if (lead_r != 8'h00) begin
                lead_r <= lead_r - 8'h01;
            end
            if (rd_evt) begin
                rdy_n_r <= 1'b1;                                           // RQ15
            end
        end
    end

endmodule : asi_dev_end

/* hdl/asi_host_end.sv */
`timescale 1ns/1ps
module asi_host_end #(
    parameter int SCLK_HALF = asi_pkg::SCLK_HALF_CYC
) (
    // System clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Serial link, host side
    asi_link_if.host         link,
    // Access request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_read,
    input  wire logic        req_recover,
    input  wire logic [1:0]  req_rs,
    input  wire logic [23:0] req_wdata,
    // Access answer
    output logic             rsp_valid,
    output logic      [23:0] rsp_data,
    // Ready pin, synchronised, active high
    output logic             data_ready
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (SCLK_HALF < asi_pkg::SCLK_HALF_CYC || SCLK_HALF > 255) begin : g_bad_half // RQ10
        $error("SCLK_HALF gives a serial clock above its limit");
    end

    typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL} asi_host_st_t;

    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
    localparam logic [5:0] RECOV_N   = 6'(asi_pkg::RECOVER_READS + asi_pkg::RESET_ONES); // RQ16

    asi_host_st_t state_r;
    logic [7:0]   div_r;
    logic [31:0]  tx_r;
    logic [23:0]  rx_r;
    logic [5:0]   bits_r;
    logic [5:0]   nbits_r;
    logic [4:0]   len_r;
    logic         read_r;
    logic         fill_r;
    logic         sclk_r;
    logic         cs_n_r;
    logic         din_r;
    logic [1:0]   miso_s_r;
    logic [1:0]   rdy_s_r;
    logic         half_end;
    logic [4:0]   len;
    logic [7:0]   cmd;
    logic [23:0]  mask;

    assign half_end = (div_r == HALF_LAST);
    assign len      = asi_pkg::reg_len(req_rs);
    assign mask     = 24'hFFFFFF >> (5'd24 - len_r);

    // Command byte for the request
    always_comb begin
        cmd = 8'h00;
        cmd[asi_pkg::CMD_RW_BIT]           = req_read;
        cmd[asi_pkg::CMD_RS_LSB +: 2]      = req_rs;
    end

    // Two-flop synchronisers for the device lines
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            miso_s_r   <= 2'h3;
            rdy_s_r    <= 2'h3;
            data_ready <= 1'b0;
        end else begin
            miso_s_r   <= {miso_s_r[0], link.miso};
            rdy_s_r    <= {rdy_s_r[0], link.rdy_n};
            data_ready <= !rdy_s_r[1];
        end
    end

    // Half-period divider
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 8'h00;
        end else if (state_r == H_IDLE || half_end) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Transfer sequencer: clock idles high, data set on falling edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= H_IDLE;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data  <= 24'h000000;
            sclk_r    <= 1'b1;                                             // RQ9
            cs_n_r    <= 1'b1;
            din_r     <= 1'b1;
            tx_r      <= 32'h00000000;
            rx_r      <= 24'h000000;
            bits_r    <= 6'h00;
            nbits_r   <= 6'h00;
            len_r     <= 5'd8;
            read_r    <= 1'b0;
            fill_r    <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state_r)
                H_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        cs_n_r    <= 1'b0;
                        bits_r    <= 6'h00;
                        len_r     <= len;
                        state_r   <= H_LEAD;
                        if (req_recover) begin
                            tx_r    <= 32'hFFFFFFFF;
                            fill_r  <= 1'b1;
                            read_r  <= 1'b0;
                            nbits_r <= RECOV_N;
                        end else begin
                            tx_r    <= {cmd, req_wdata << (5'd24 - len)}; // RQ4
                            fill_r  <= 1'b0;
                            read_r  <= req_read;
                            nbits_r <= 6'(len) + 6'd8;
                        end
                    end
                end
                H_LEAD, H_HIGH: begin
                    if (half_end) begin
                        sclk_r  <= 1'b0;
                        din_r   <= (read_r && bits_r >= 6'd8) ? 1'b0 : tx_r[31];
                        state_r <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_end) begin
                        sclk_r  <= 1'b1;
                        rx_r    <= {rx_r[22:0], miso_s_r[1]};
                        tx_r    <= {tx_r[30:0], fill_r};
                        bits_r  <= bits_r + 6'h01;
                        state_r <= (bits_r + 6'h01 == nbits_r) ? H_TAIL : H_HIGH;
                    end
                end
                H_TAIL: begin
                    if (half_end) begin
                        cs_n_r    <= 1'b1;
                        din_r     <= 1'b1;
                        rsp_valid <= read_r;
                        rsp_data  <= rx_r & mask;
                        state_r   <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.cs_n = cs_n_r;
    assign link.din  = din_r;

endmodule : asi_host_end

/* sim/asi_link_asserts.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// Link protocol checks
// ------------------------------------------------
module asi_link_asserts (
    // System domain
    input wire logic clock,
    input wire logic reset_n,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic rdy_n
);
    logic [6:0] cnt_r;
    logic [7:0] cmd_r;

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Rising serial clocks within the current frame
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) cnt_r <= 7'h00;
        else if (cs_n) cnt_r <= 7'h00;
        else if ($rose(sclk)) cnt_r <= cnt_r + 7'h01;
    end

    // Command byte as seen on the data input
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) cmd_r <= 8'h00;
        else if (!cs_n && $rose(sclk) && cnt_r < 7'h08) cmd_r <= {cmd_r[6:0], din};
    end

    a_idle_clk_high: assert property (cs_n |-> sclk)
        else $error("serial clock low outside a frame");
    a_idle_released: assert property (cs_n |-> dout_oe_n)
        else $error("data out driven while deselected");
    a_dout_hold: assert property (!cs_n && sclk && $past(sclk) |-> $stable(dout))
        else $error("data out changed while clock high");
    a_drive_on_fall: assert property ($fell(dout_oe_n) |-> !sclk)
        else $error("data out enabled outside a falling edge");
    a_cmd_quiet: assert property (!cs_n && cnt_r < 7'h08 |-> dout_oe_n)
        else $error("data out driven during command byte");
    a_write_quiet: assert property (!cs_n && cnt_r >= 7'h08 && !cmd_r[6] |-> dout_oe_n)
        else $error("data out driven during write");
    a_read_armed: assert property ($rose(sclk) && !cs_n && cnt_r == 7'h08 && cmd_r[6]
        |-> !dout_oe_n)
        else $error("read not armed after command byte");
    a_rdy_after_read: assert property ($rose(sclk) && !cs_n && cnt_r == 7'h17
        && cmd_r == 8'h43 |-> ##[1:12] rdy_n)
        else $error("ready not cleared after data read");
    a_clk_rate: assert property ($changed(sclk) |=> $stable(sclk) [*3])
        else $error("serial clock half period too short");
endmodule : asi_link_asserts

/* sim/adc_serial_host_interface_tb.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// Both ends joined, driven from the host user side and the device result inputs
// ------------------------------------------------
module adc_serial_host_interface_tb;
    logic        clock, reset_n, req_valid, req_read, req_recover, result_valid;
    logic        req_ready, rsp_valid, data_ready, iface_reset, saw_reset;
    logic [1:0]  req_rs;
    logic [7:0]  filter_q;
    logic [15:0] result_data;
    logic [23:0] req_wdata, rsp_data, config_q;
    int          miscompares, comparisons, rsp_seen;

    asi_link_if asi_link_if_i ();
    asi_dev_end asi_dev_end_i (.clock, .reset_n, .link(asi_link_if_i.dev), .result_data,
        .result_valid, .config_q, .filter_q, .iface_reset);
    asi_host_end asi_host_end_i (.clock, .reset_n, .link(asi_link_if_i.host), .req_valid,
        .req_ready, .req_read, .req_recover, .req_rs, .req_wdata, .rsp_valid, .rsp_data,
        .data_ready);
    asi_link_asserts asi_link_asserts_i (.clock, .reset_n, .sclk(asi_link_if_i.sclk),
        .cs_n(asi_link_if_i.cs_n), .din(asi_link_if_i.din), .dout(asi_link_if_i.dout),
        .dout_oe_n(asi_link_if_i.dout_oe_n), .rdy_n(asi_link_if_i.rdy_n));

    // System clock
    always #25 clock = ~clock;

    // Remember a port reset pulse
    always @(posedge clock) if (iface_reset === 1'b1) saw_reset <= 1'b1;

    // Count read answers away from the launching edge
    always @(negedge clock) if (rsp_valid === 1'b1) rsp_seen++;

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Wait until the host end is idle again
    task automatic wait_idle;
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge clock);
            #2;
            n++;
        end
        if (n == 3000) chk("idle", 24'h0, 24'h1);
    endtask : wait_idle

    // One complete access through the host end
    task automatic access(input logic rd, input logic rcv, input logic [1:0] rs,
                          input logic [23:0] wd);
        wait_idle();
        req_valid   = 1'b1;
        req_read    = rd;
        req_recover = rcv;
        req_rs      = rs;
        req_wdata   = wd;
        @(posedge clock);
        #2;
        req_valid = 1'b0;
        wait_idle();
    endtask : access

    task automatic t_regs;
        access(1'b0, 1'b0, asi_pkg::RS_CONFIG, 24'hA5C3E1);
        access(1'b0, 1'b0, asi_pkg::RS_FILTER, 24'h00005A);
        chk("config_q", config_q, 24'hA5C3E1);
        access(1'b1, 1'b0, asi_pkg::RS_CONFIG, 24'h000000);
        chk("config read", rsp_data, 24'hA5C3E1);
        chk("filter_q", {16'h0000, filter_q}, 24'h00005A);
        access(1'b1, 1'b0, asi_pkg::RS_FILTER, 24'h000000);
        chk("filter read", rsp_data, 24'h00005A);
        chk("rsp count", 24'(rsp_seen), 24'h000002);
    endtask : t_regs

    task automatic t_ready;
        result_data  = 16'hBEEF;
        result_valid = 1'b1;
        @(posedge clock);
        #2;
        result_valid = 1'b0;
        repeat (12) @(posedge clock);
        chk("ready pin", {23'h0, data_ready}, 24'h1);
        access(1'b1, 1'b0, asi_pkg::RS_STATUS, 24'h000000);
        chk("ready bit", {23'h0, rsp_data[7]}, 24'h1);
        access(1'b0, 1'b0, asi_pkg::RS_DATA, 24'h001234);
        access(1'b1, 1'b0, asi_pkg::RS_DATA, 24'h000000);
        chk("data read", rsp_data, 24'h00BEEF);
        repeat (12) @(posedge clock);
        chk("ready cleared", {23'h0, data_ready}, 24'h0);
        access(1'b1, 1'b0, asi_pkg::RS_STATUS, 24'h000000);
        chk("bit cleared", {23'h0, rsp_data[7]}, 24'h0);
    endtask : t_ready

    task automatic t_recover;
        access(1'b0, 1'b1, asi_pkg::RS_STATUS, 24'h000000);
        access(1'b0, 1'b0, asi_pkg::RS_FILTER, 24'h0000C3);
        chk("port reset", {23'h0, saw_reset}, 24'h1);
        chk("config reset", config_q, asi_pkg::CONFIG_RST);
        access(1'b1, 1'b0, asi_pkg::RS_FILTER, 24'h000000);
        chk("after recover", rsp_data, 24'h0000C3);
    endtask : t_recover

    // Main sequence
    initial begin
        clock        = 1'b0;
        reset_n      = 1'b0;
        req_valid    = 1'b0;
        req_read     = 1'b0;
        req_recover  = 1'b0;
        req_rs       = 2'h0;
        req_wdata    = 24'h000000;
        result_data  = 16'h0000;
        result_valid = 1'b0;
        saw_reset    = 1'b0;
        miscompares  = 0;
        comparisons  = 0;
        rsp_seen     = 0;
        repeat (8) @(posedge clock);
        #2;
        reset_n = 1'b1;
        t_regs();
        t_ready();
        t_recover();
        close_out();
    end

    // Watchdog against a hang
    initial begin
        #1500000;
        miscompares++;
        close_out();
    end
endmodule : adc_serial_host_interface_tb
